// *** design/err_status_pkg.sv ***
// Constants and carriers for the host error status reporter.
// Assumes one 125 MHz clock and plain-port event inputs from controller logic.
package err_status_pkg;
    // Reject group bit positions
    localparam int unsigned REJ_CHAN_PARITY = 0;
    localparam int unsigned REJ_ILL_OPCODE = 1;
    localparam int unsigned REJ_MOD_ADDR = 2;
    localparam int unsigned REJ_ADDR_BOUNDS = 3;
    localparam int unsigned REJ_PARAM_BOUNDS = 4;
    localparam int unsigned REJ_ILL_PARAM = 5;
    localparam int unsigned REJ_MSG_SEQ = 6;
    localparam int unsigned REJ_MSG_LEN = 7;
    // Fault group bit positions
    localparam int unsigned FLT_CROSS_UNIT = 0;
    localparam int unsigned FLT_CTRL = 1;
    localparam int unsigned FLT_UNIT = 2;
    localparam int unsigned FLT_DIAG_RESULT = 3;
    localparam int unsigned FLT_OPER_REQ = 4;
    localparam int unsigned FLT_DIAG_REQ = 5;
    localparam int unsigned FLT_INT_MAINT = 6;
    localparam int unsigned FLT_POWER_FAIL = 7;
    localparam int unsigned FLT_RETRANSMIT = 8;
    // Access group bit positions
    localparam int unsigned ACC_ILL_PARALLEL = 0;
    localparam int unsigned ACC_UNINIT_MEDIA = 1;
    localparam int unsigned ACC_NO_SPARES = 2;
    localparam int unsigned ACC_NOT_READY = 3;
    localparam int unsigned ACC_WRITE_PROT = 4;
    localparam int unsigned ACC_NO_DATA = 5;
    localparam int unsigned ACC_UNREC_OVFL = 6;
    localparam int unsigned ACC_UNREC_DATA = 7;
    localparam int unsigned ACC_END_FILE = 8;
    localparam int unsigned ACC_END_VOLUME = 9;
    // Information group bit positions
    localparam int unsigned INF_OPER_REQ = 0;
    localparam int unsigned INF_DIAG_REQ = 1;
    localparam int unsigned INF_INT_MAINT = 2;
    localparam int unsigned INF_MEDIA_WEAR = 3;
    localparam int unsigned INF_LATENCY = 4;
    localparam int unsigned INF_AUTO_SPARE = 5;
    localparam int unsigned INF_REC_OVFL = 6;
    localparam int unsigned INF_MARGINAL = 7;
    localparam int unsigned INF_RECOVERABLE = 8;
    localparam int unsigned INF_MAINT_OVFL = 9;

    // Masks of bits that may ever be set in each group
    localparam logic [7:0] REJ_IMPL_MASK = 8'hff;
    localparam logic [8:0] FLT_IMPL_MASK = 9'h08e;
    localparam logic [9:0] ACC_IMPL_MASK = 10'h2c4;
    localparam logic [9:0] INF_IMPL_MASK = 10'h0b8;

    // Accepted addressing
    localparam logic [3:0] VOL_ONLY = 4'h0;
    localparam logic [3:0] UNIT_DISC = 4'h1;
    localparam logic [3:0] UNIT_CTRL = 4'hf;

    // Command classes as decoded by the opcode table
    typedef enum logic [1:0]
    {
        CMD_IMPL = 2'b00,
        CMD_NOOP = 2'b01,
        CMD_NONE = 2'b10
    } cmd_class_t;

    // One incoming command as seen by the checker
    typedef struct packed
    {
        logic valid;
        logic [7:0] opcode;
        logic [3:0] unit;
        logic [3:0] volume;
        logic param_ok;
    } cmd_t;

    // Full status report carried to the host side
    typedef struct packed
    {
        logic [7:0] reject;
        logic [8:0] fault;
        logic [9:0] access;
        logic [9:0] info;
    } status_t;
endpackage : err_status_pkg

// *** design/err_status_reporter.sv ***
// Error status report bits gathered for the host status answer.
// Assumes event inputs are one-cycle pulses synchronous to ref_clk and that
// opcode classing comes from a table supplied as a parameter.
module err_status_reporter
    import err_status_pkg::*;
#(
    parameter logic [255:0] NOOP_OPS = 256'h0,
    parameter logic [255:0] IMPL_OPS = {256{1'b1}}
)
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire cmd_t cmd,
    input wire status_t raw_event,
    input wire logic clear_report,
    output status_t report,
    output logic report_pending
);
    status_t ev_d;
    status_t rep_d;
    status_t rep_q;
    cmd_class_t cls;
    wire logic addr_bad;
    wire logic opcode_bad;
    wire logic param_bad;

    // Opcode table lookup shared by both reject checks
    function automatic cmd_class_t class_of(input logic [7:0] op);
        if (NOOP_OPS[op])
            return CMD_NOOP;
        else if (IMPL_OPS[op])
            return CMD_IMPL;
        else
            return CMD_NONE;
    endfunction : class_of

    // Command checks
    assign cls = class_of(cmd.opcode);
    assign addr_bad = cmd.valid && ((cmd.volume != VOL_ONLY) ||
        ((cmd.unit != UNIT_DISC) && (cmd.unit != UNIT_CTRL)));
    assign opcode_bad = cmd.valid && (cls == CMD_NONE);
    // No-op commands do nothing else but still have parameters checked
    assign param_bad = cmd.valid && (cls != CMD_NONE) && !cmd.param_ok;

    // Merge events; the masks hold unsupported bits at zero forever,
    // so a faulty upstream source cannot leak them to the host.
    always_comb
    begin
        ev_d = raw_event;
        ev_d.reject[REJ_MOD_ADDR] = raw_event.reject[REJ_MOD_ADDR] | addr_bad;
        ev_d.reject[REJ_ILL_OPCODE] = raw_event.reject[REJ_ILL_OPCODE]
            | opcode_bad;
        ev_d.reject[REJ_ILL_PARAM] = raw_event.reject[REJ_ILL_PARAM]
            | param_bad;
        ev_d.reject = ev_d.reject & REJ_IMPL_MASK;
        ev_d.fault = ev_d.fault & FLT_IMPL_MASK;
        ev_d.access = ev_d.access & ACC_IMPL_MASK;
        ev_d.info = ev_d.info & INF_IMPL_MASK;
    end

    // Sticky: a new event in the clearing cycle survives the clear
    assign rep_d = clear_report ? ev_d : (rep_q | ev_d);

    // Report register
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            rep_q <= '0;
        else
            rep_q <= rep_d;
    end

    assign report = rep_q;
    assign report_pending = |rep_q;

    chk_addr_reject: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cmd.valid && cmd.volume != VOL_ONLY) |=> report.reject[REJ_MOD_ADDR])
        else $error("addressing reject missed");
    chk_opcode_reject: assert property (@(posedge ref_clk) disable iff (sys_rst)
        opcode_bad |=> report.reject[REJ_ILL_OPCODE])
        else $error("illegal opcode missed");
    chk_noop_param: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cmd.valid && cls == CMD_NOOP && !cmd.param_ok)
        |=> report.reject[REJ_ILL_PARAM])
        else $error("illegal parameter missed");
    chk_unit_fault: assert property (@(posedge ref_clk) disable iff (sys_rst)
        raw_event.fault[FLT_UNIT] |=> report.fault[FLT_UNIT])
        else $error("unit fault missed");
    chk_diag_fault: assert property (@(posedge ref_clk) disable iff (sys_rst)
        raw_event.fault[FLT_DIAG_RESULT] |=> report.fault[FLT_DIAG_RESULT])
        else $error("diagnostic fault missed");
    chk_fault_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (report.fault & ~FLT_IMPL_MASK) == '0)
        else $error("unsupported fault bit set");
    chk_access_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (report.access & ~ACC_IMPL_MASK) == '0)
        else $error("unsupported access bit set");
    chk_info_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (report.info & ~INF_IMPL_MASK) == '0)
        else $error("unsupported info bit set");
    chk_sticky_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (report.reject[REJ_CHAN_PARITY] && !clear_report)
        |=> report.reject[REJ_CHAN_PARITY])
        else $error("sticky bit lost");
    cov_addr: cover property (@(posedge ref_clk) addr_bad);
    cov_opcode: cover property (@(posedge ref_clk) opcode_bad);
    cov_clear_set: cover property (@(posedge ref_clk)
        clear_report && (ev_d != '0));
endmodule : err_status_reporter

// *** verif/host_model.sv ***
// Host side model: reads each pending status report once and clears it.
// Assumes report and report_pending come from the reporter on ref_clk.
module host_model
    import err_status_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire status_t report,
    input wire logic report_pending,
    output logic clear_report,
    output logic got,
    output status_t snap
);
    timeunit 1ns;
    timeprecision 1ps;
    // Read and clear; the clear cycle blocks a second read of one report
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            clear_report <= 1'b0;
            got <= 1'b0;
            snap <= '0;
        end
        else
        begin
            got <= report_pending && !clear_report;
            clear_report <= report_pending && !clear_report;
            snap <= report;
        end
    end
endmodule : host_model

// *** verif/err_status_reporter_bench.sv ***
// Self-checking bench for the error status reporter.
// Assumes the host model clears every report that it reads.
module err_status_reporter_bench
    import err_status_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] BAD_OP = 8'h55;
    localparam logic [7:0] NOP_OP = 8'h33;
    localparam int N = 300;
    logic ref_clk;
    logic sys_rst;
    logic clear_report;
    logic report_pending;
    logic got;
    cmd_t cmd;
    status_t raw_event;
    status_t report;
    status_t snap;
    status_t exp_q[$];
    int miscompares = 0;
    int n_tests = 0;
    // One opcode left out of the table, one treated as a no-op
    err_status_reporter #(
        .NOOP_OPS(256'h1 << NOP_OP),
        .IMPL_OPS(~(256'h1 << BAD_OP))
    ) err_status_reporter_inst (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .cmd(cmd),
        .raw_event(raw_event),
        .clear_report(clear_report),
        .report(report),
        .report_pending(report_pending)
    );
    host_model host_model_inst (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .report(report),
        .report_pending(report_pending),
        .clear_report(clear_report),
        .got(got),
        .snap(snap)
    );
    task automatic compare_s(input status_t act, input status_t exp_v);
        n_tests++;
        if (act !== exp_v)
        begin
            miscompares++;
            $display("unexpected at %0t: %h not %h", $time, act, exp_v);
        end
    endtask : compare_s
    task automatic tally_and_finish();
        if (miscompares == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    // One command plus random raw events; addressing biased to edge cases
    task automatic one_test();
        cmd_t c;
        status_t r;
        status_t e;
        c.valid = 1'b1;
        c.opcode = ($urandom % 2) ? NOP_OP : 8'($urandom);
        c.opcode = ($urandom % 3 == 0) ? BAD_OP : c.opcode;
        c.unit = ($urandom % 2) ? (($urandom % 2) ? 4'h1 : 4'hf) : 4'($urandom);
        c.volume = ($urandom % 2) ? 4'h0 : 4'($urandom);
        c.param_ok = 1'($urandom);
        if (c.opcode == BAD_OP)
            c = '{1'b1, BAD_OP, UNIT_DISC, VOL_ONLY, c.param_ok};
        r = 37'({$urandom, $urandom});
        r.reject[REJ_CHAN_PARITY] = 1'b1; // Keeps every report non-empty
        e.reject = r.reject;
        e.fault = r.fault & FLT_IMPL_MASK;
        e.access = r.access & ACC_IMPL_MASK;
        e.info = r.info & INF_IMPL_MASK;
        if (c.volume != VOL_ONLY || !(c.unit inside {UNIT_DISC, UNIT_CTRL}))
            e.reject[REJ_MOD_ADDR] = 1'b1;
        if (c.opcode == BAD_OP)
            e.reject[REJ_ILL_OPCODE] = 1'b1;
        else if (!c.param_ok)
            e.reject[REJ_ILL_PARAM] = 1'b1;
        @(negedge ref_clk);
        cmd <= c;
        raw_event <= r;
        exp_q.push_back(e);
        @(negedge ref_clk);
        cmd <= '0;
        raw_event <= '0;
        repeat (4) @(negedge ref_clk);
        compare_s(report, '0);
    endtask : one_test
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Result watcher: each host read takes the oldest expectation
    always @(posedge ref_clk)
    begin
        if (got === 1'b1)
            compare_s(snap, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
    end
    initial
    begin
        sys_rst = 1'b1;
        cmd = '0;
        raw_event = '0;
        void'($urandom(84444));
        repeat (4) @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (N) one_test();
        tally_and_finish();
    end
    // Watchdog sized well above the expected run length
    initial
    begin
        #(N * 64 + 1000);
        miscompares++;
        tally_and_finish();
    end
endmodule : err_status_reporter_bench
